// ### hdl/csfm_consts.svh
// Constants for the clock switch and fail monitor block
`ifndef CSFM_CONSTS_SVH
`define CSFM_CONSTS_SVH
// Register byte offsets
`define CSFM_OFS_OSC 4'h0
`define CSFM_OFS_PLL 4'h4
`define CSFM_OFS_TUNE 4'h8
`define CSFM_OFS_KEY 4'hc
// Unlock keys, arbitrary values
`define CSFM_KEY1 16'h3c3c
`define CSFM_KEY2 16'hc3c3
// Reset values and settle tick count
`define CSFM_PLL_RST 9'h030
`define CSFM_TUNE_RST 6'h00
`define CSFM_SETTLE_TICKS 4'ha
// Source select codes and external primary submode code
`define CSFM_SRC_FRC 3'h0
`define CSFM_SRC_FAST_RC_WITH_PLL 3'h1
`define CSFM_SRC_PRI 3'h2
`define CSFM_SRC_PRIPLL 3'h3
`define CSFM_SRC_SEC 3'h4
`define CSFM_SRC_LOW_POWER_RC_OSC 3'h5
`define CSFM_SUB_EXT 2'h0
// Control register field positions
`define CSFM_B_SWITCH_REQUEST 0
`define CSFM_B_LPOSC 1
`define CSFM_B_CF 3
`define CSFM_B_LOCK 5
`define CSFM_B_CLKLK 7
`define CSFM_NEW_SOURCE_SELECT_LSB 8
`define CSFM_CURRENT_SOURCE_STATUS_LSB 12
// Oscillator enable vector bits
`define CSFM_EN_FRC 0
`define CSFM_EN_PRI 1
`define CSFM_EN_SEC 2
`define CSFM_EN_LOW_POWER_RC_OSC 3
`define CSFM_EN_PLL 4
// Synchroniser lanes
`define CSFM_SI_OST 0
`define CSFM_SI_LOCK 1
`define CSFM_SI_FAIL 2
`define CSFM_SI_TICK 3
`endif

// ### hdl/csfm_pkg.sv
// Types of the clock switch and fail monitor block
package csfm_pkg;
   typedef enum logic [4:0] {
      CSFM_IDLE = 5'h01,
      CSFM_CHECK = 5'h02,
      CSFM_WAIT = 5'h04,
      CSFM_SETTLE = 5'h08,
      CSFM_SWAP = 5'h10
   } csfm_state_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] q;
   } csfm_sync_st_t;

   typedef struct packed {
      logic first;
      logic armed;
   } csfm_unlk_st_t;

   typedef struct packed {
      csfm_state_t st;
      logic ack;
      logic [31:0] rdata;
      logic [8:0] pll_div;
      logic [5:0] tune;
      logic [2:0] current_source_status;
      logic [2:0] new_source_select;
      logic switch_request;
      logic secondary_osc_enable;
      logic clock_source_lock;
      logic lock;
      logic cf;
      logic trap;
      logic loaded;
      logic tick_prev;
      logic fail_prev;
      logic [3:0] ticks;
      logic [4:0] osc_en;
   } csfm_top_st_t;
endpackage

// ### hdl/csfm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module csfm_sync (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [3:0] i_async,
   output logic [3:0] o_level
);
   import csfm_pkg::*;

   csfm_sync_st_t r;
   csfm_sync_st_t n;

   // Shift chain; output follows once stages two and three agree
   always_comb begin
      n = r;
      n.s1 = i_async;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_level = r.q;
endmodule

// ### hdl/csfm_unlock.sv
// Two-key unlock gate for control register writes
`timescale 1ns/1ps
`include "csfm_consts.svh"
module csfm_unlock (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_bus_wr,
   input wire logic i_key_wr,
   input wire logic [15:0] i_key_data,
   output logic o_unlocked
);
   import csfm_pkg::*;

   csfm_unlk_st_t r;
   csfm_unlk_st_t n;

   // Any accepted write moves the key tracker; one write consumes it
   always_comb begin
      n = r;
      if (i_bus_wr) begin
         n.first = 1'b0;
         n.armed = 1'b0;
         if (i_key_wr && i_key_data == `CSFM_KEY1) begin
            n.first = 1'b1;
         end else if (i_key_wr && r.first && i_key_data == `CSFM_KEY2) begin
            n.armed = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_unlocked = r.armed;
endmodule

// ### hdl/csfm_top.sv
// Clock switch sequencer and fail monitor with Avalon-MM registers
`timescale 1ns/1ps
`include "csfm_consts.svh"
module csfm_top (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_cfg_switch_monitor,
   input wire logic i_cfg_monitor_off,
   input wire logic [2:0] i_cfg_initial_source,
   input wire logic [1:0] i_cfg_primary_submode,
   input wire logic i_wdt_enable,
   input wire logic i_sleep,
   input wire logic i_osc_startup_done,
   input wire logic i_pll_locked,
   input wire logic i_osc_fail,
   input wire logic i_new_clk_toggle,
   output logic [2:0] o_sys_source,
   output logic [4:0] o_osc_enable,
   output logic [8:0] o_pll_feedback_divisor,
   output logic [5:0] o_rc_tune_field,
   output logic o_clock_fail_trap,
   output logic o_switch_busy
);
   import csfm_pkg::*;

   //-----------------------------------------------------------
   // Source decode
   //-----------------------------------------------------------

   // Oscillators that a source select needs running
   function automatic logic [4:0] src_needs(input logic [2:0] src);
      logic [4:0] v;
      v = 5'h00;
      case (src)
         `CSFM_SRC_FAST_RC_WITH_PLL: begin
            v[`CSFM_EN_FRC] = 1'b1;
            v[`CSFM_EN_PLL] = 1'b1;
         end
         `CSFM_SRC_PRI: begin
            v[`CSFM_EN_PRI] = 1'b1;
         end
         `CSFM_SRC_PRIPLL: begin
            v[`CSFM_EN_PRI] = 1'b1;
            v[`CSFM_EN_PLL] = 1'b1;
         end
         `CSFM_SRC_SEC: begin
            v[`CSFM_EN_SEC] = 1'b1;
         end
         `CSFM_SRC_LOW_POWER_RC_OSC: begin
            v[`CSFM_EN_LOW_POWER_RC_OSC] = 1'b1;
         end
         default: begin
            v[`CSFM_EN_FRC] = 1'b1;
         end
      endcase
      return v;
   endfunction

   //-----------------------------------------------------------
   // State and helpers
   //-----------------------------------------------------------

   csfm_top_st_t r;
   csfm_top_st_t n;
   logic [3:0] syn_q;
   logic [31:0] rd_word;
   logic [4:0] cur_need;
   logic [4:0] tgt_need;
   logic sw_en;
   logic mon_en;
   logic req;
   logic rd_go;
   logic wr_go;
   logic key_wr;
   logic osc_wr;
   logic unlocked;
   logic tick_ev;
   logic fail_ev;
   logic need_ost;
   logic ready;
   logic sw_blocked;

   // Config decode and bus handshake
   assign sw_en = ~i_cfg_switch_monitor;
   assign mon_en = sw_en & ~i_cfg_monitor_off;
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~r.ack;
   assign rd_go = i_avs_read & ~r.ack;
   assign wr_go = i_avs_write & r.ack;
   assign key_wr = wr_go & (i_avs_address == `CSFM_OFS_KEY);
   assign osc_wr = wr_go & unlocked & (i_avs_address == `CSFM_OFS_OSC);

   // Asynchronous oscillator-side inputs
   csfm_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_async({i_new_clk_toggle, i_osc_fail, i_pll_locked,
                i_osc_startup_done}),
      .o_level(syn_q)
   );

   // Key pair gate for the control register
   csfm_unlock u_unlock (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_bus_wr(wr_go),
      .i_key_wr(key_wr),
      .i_key_data(i_avs_writedata[15:0]),
      .o_unlocked(unlocked)
   );

   // Events and readiness of the target source
   assign cur_need = src_needs(r.current_source_status);
   assign tgt_need = src_needs(r.new_source_select);
   assign tick_ev = syn_q[`CSFM_SI_TICK] ^ r.tick_prev;
   assign fail_ev = mon_en & r.loaded & syn_q[`CSFM_SI_FAIL] & ~r.fail_prev;
   assign need_ost = (tgt_need[`CSFM_EN_PRI] &
                      (i_cfg_primary_submode != `CSFM_SUB_EXT)) |
                     tgt_need[`CSFM_EN_SEC];
   assign ready = (~need_ost | syn_q[`CSFM_SI_OST]) &
                  (~tgt_need[`CSFM_EN_PLL] | syn_q[`CSFM_SI_LOCK]);
   assign sw_blocked = r.clock_source_lock & ~mon_en;

   //-----------------------------------------------------------
   // Register read mux
   //-----------------------------------------------------------

   // Unimplemented bits stay zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (i_avs_address)
         `CSFM_OFS_OSC: begin
            rd_word[`CSFM_CURRENT_SOURCE_STATUS_LSB +: 3] = r.current_source_status;
            rd_word[`CSFM_NEW_SOURCE_SELECT_LSB +: 3] = r.new_source_select;
            rd_word[`CSFM_B_CLKLK] = r.clock_source_lock;
            rd_word[`CSFM_B_LOCK] = r.lock;
            rd_word[`CSFM_B_CF] = r.cf;
            rd_word[`CSFM_B_LPOSC] = r.secondary_osc_enable;
            rd_word[`CSFM_B_SWITCH_REQUEST] = r.switch_request;
         end
         `CSFM_OFS_PLL: begin
            rd_word[8:0] = r.pll_div;
         end
         `CSFM_OFS_TUNE: begin
            rd_word[5:0] = r.tune;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   //-----------------------------------------------------------
   // Next-state logic
   //-----------------------------------------------------------

   always_comb begin
      n = r;
      n.trap = 1'b0;
      n.tick_prev = syn_q[`CSFM_SI_TICK];
      n.fail_prev = syn_q[`CSFM_SI_FAIL];
      n.ack = req & ~r.ack;
      if (rd_go) begin
         n.rdata = rd_word;
      end
      // Initial source taken after reset release
      if (!r.loaded) begin
         n.loaded = 1'b1;
         n.current_source_status = i_cfg_initial_source;
         n.new_source_select = i_cfg_initial_source;
      end
      // Multiplier and tuning writes, byte lanes honoured
      if (wr_go && i_avs_address == `CSFM_OFS_PLL) begin
         if (i_avs_byteenable[0]) begin
            n.pll_div[7:0] = i_avs_writedata[7:0];
         end
         if (i_avs_byteenable[1]) begin
            n.pll_div[8] = i_avs_writedata[8];
         end
      end
      if (wr_go && i_avs_address == `CSFM_OFS_TUNE && i_avs_byteenable[0])
      begin
         n.tune = i_avs_writedata[5:0];
      end
      // Control high byte: new source, frozen while a switch runs
      if (osc_wr && i_avs_byteenable[1] && r.st == CSFM_IDLE) begin
         n.new_source_select = i_avs_writedata[`CSFM_NEW_SOURCE_SELECT_LSB +: 3];
      end
      // Control low byte: lock, secondary enable, flag clear, request
      if (osc_wr && i_avs_byteenable[0]) begin
         n.clock_source_lock = i_avs_writedata[`CSFM_B_CLKLK];
         n.secondary_osc_enable = i_avs_writedata[`CSFM_B_LPOSC];
         if (!i_avs_writedata[`CSFM_B_CF]) begin
            n.cf = 1'b0;
         end
         if (i_avs_writedata[`CSFM_B_SWITCH_REQUEST] && !sw_blocked &&
             r.st == CSFM_IDLE) begin
            n.switch_request = 1'b1;
         end
      end
      // Live PLL lock status
      n.lock = syn_q[`CSFM_SI_LOCK] & r.osc_en[`CSFM_EN_PLL];
      // Switch sequencer
      case (r.st)
         CSFM_IDLE: begin
            if (r.switch_request) begin
               n.st = CSFM_CHECK;
            end
         end
         CSFM_CHECK: begin
            if (r.new_source_select == r.current_source_status) begin
               n.switch_request = 1'b0;
               n.st = CSFM_IDLE;
            end else begin
               n.lock = 1'b0;
               n.cf = 1'b0;
               n.st = CSFM_WAIT;
            end
         end
         CSFM_WAIT: begin
            if (ready) begin
               n.ticks = 4'h0;
               n.st = CSFM_SETTLE;
            end
         end
         CSFM_SETTLE: begin
            if (tick_ev) begin
               n.ticks = r.ticks + 4'h1;
               if (r.ticks == `CSFM_SETTLE_TICKS - 4'h1) begin
                  n.st = CSFM_SWAP;
               end
            end
         end
         CSFM_SWAP: begin
            n.current_source_status = r.new_source_select;
            n.switch_request = 1'b0;
            n.st = CSFM_IDLE;
         end
         default: begin
            n.st = CSFM_IDLE;
         end
      endcase
      // Switching disabled: initial config rules, request held low
      if (!sw_en) begin
         n.current_source_status = i_cfg_initial_source;
         n.switch_request = 1'b0;
         n.st = CSFM_IDLE;
      end
      // Fail-safe fallback overrides any switch; set beats clear
      if (fail_ev) begin
         n.trap = 1'b1;
         n.cf = 1'b1;
         n.switch_request = 1'b0;
         n.st = CSFM_IDLE;
         if (cur_need[`CSFM_EN_PLL]) begin
            n.current_source_status = `CSFM_SRC_FAST_RC_WITH_PLL;
            n.new_source_select = `CSFM_SRC_FAST_RC_WITH_PLL;
         end else begin
            n.current_source_status = `CSFM_SRC_FRC;
            n.new_source_select = `CSFM_SRC_FRC;
         end
      end
      // Oscillator enables: current, plus target while switching
      n.osc_en = cur_need |
                 ((r.st != CSFM_IDLE) ? tgt_need : 5'h00);
      n.osc_en[`CSFM_EN_LOW_POWER_RC_OSC] = cur_need[`CSFM_EN_LOW_POWER_RC_OSC] |
                                tgt_need[`CSFM_EN_LOW_POWER_RC_OSC] & (r.st != CSFM_IDLE) |
                                i_wdt_enable | (mon_en & ~i_sleep);
      n.osc_en[`CSFM_EN_SEC] = n.osc_en[`CSFM_EN_SEC] | r.secondary_osc_enable;
   end

   //-----------------------------------------------------------
   // State register
   //-----------------------------------------------------------

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '{st: CSFM_IDLE, pll_div: `CSFM_PLL_RST,
                tune: `CSFM_TUNE_RST, default: '0};
      end else begin
         r <= n;
      end
   end

   // Outputs, all from the state register but waitrequest
   assign o_avs_readdata = r.rdata;
   assign o_sys_source = r.current_source_status;
   assign o_osc_enable = r.osc_en;
   assign o_pll_feedback_divisor = r.pll_div;
   assign o_rc_tune_field = r.tune;
   assign o_clock_fail_trap = r.trap;
   assign o_switch_busy = r.switch_request;

   //-----------------------------------------------------------
   // Assertions
   //-----------------------------------------------------------

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_swap_step;
      r.st == CSFM_SWAP && sw_en && !fail_ev;
   endsequence

   sequence s_swap_done;
      ##1 (r.st == CSFM_IDLE && !r.switch_request);
   endsequence

   AST_REDUNDANT: assert property (
      (r.st == CSFM_CHECK && r.new_source_select == r.current_source_status && sw_en && !fail_ev)
      |=> (r.st == CSFM_IDLE && !r.switch_request))
      else $error("redundant switch not aborted");

   AST_START_CLEAR: assert property (
      (r.st == CSFM_CHECK && r.new_source_select != r.current_source_status && sw_en && !fail_ev)
      |=> (!r.lock && !r.cf && r.st == CSFM_WAIT))
      else $error("switch start did not clear status");

   AST_SETTLE_TEN: assert property (
      (r.st == CSFM_SETTLE && !tick_ev) |-> (r.ticks < `CSFM_SETTLE_TICKS))
      else $error("settle count overran");

   AST_SETTLE_EXIT: assert property (
      (r.st == CSFM_SETTLE && sw_en && !fail_ev && tick_ev &&
       r.ticks == `CSFM_SETTLE_TICKS - 4'h1) |=> r.st == CSFM_SWAP)
      else $error("switch not taken after settle count");

   AST_SWAP_DONE: assert property (
      s_swap_step |-> s_swap_done ##0 (r.current_source_status == $past(r.new_source_select)))
      else $error("current source not updated at switch end");

   AST_DISABLED: assert property (
      (!sw_en && $past(!sw_en) && r.loaded) |-> (!r.switch_request &&
       r.st == CSFM_IDLE && r.current_source_status == $past(i_cfg_initial_source)))
      else $error("switching active while disabled");

   AST_FAIL_TRAP: assert property (
      fail_ev |=> (o_clock_fail_trap && r.cf) ##1 !o_clock_fail_trap)
      else $error("failure did not raise one trap pulse");

   AST_FALLBACK_PLL: assert property (
      (fail_ev && cur_need[`CSFM_EN_PLL]) |=> r.current_source_status == `CSFM_SRC_FAST_RC_WITH_PLL)
      else $error("fallback did not keep the PLL");

   AST_CF_HOLD: assert property (
      (r.cf && !osc_wr && r.st != CSFM_CHECK) |=> r.cf)
      else $error("fail flag dropped without a clear");

   AST_LOW_POWER_RC_OSC_ON: assert property (
      (mon_en && !i_sleep) |=> o_osc_enable[`CSFM_EN_LOW_POWER_RC_OSC])
      else $error("low-power RC stopped under monitor");

   AST_RSV_ZERO: assert property (
      (i_avs_read && !o_avs_waitrequest &&
       $past(i_avs_address) == `CSFM_OFS_PLL) |-> o_avs_readdata[31:9] == 0)
      else $error("reserved multiplier bits read nonzero");

   AST_CLOCK_SOURCE_LOCK: assert property (
      (sw_blocked && r.st == CSFM_IDLE && !r.switch_request) |=> !r.switch_request)
      else $error("switch requested while source locked");

   AST_WAIT_READY: assert property (
      (r.st == CSFM_WAIT && !ready) |=> r.st != CSFM_SETTLE)
      else $error("settle entered before source ready");
endmodule

// ### bench/csfm_osc_model.sv
// Behavioural oscillators, start-up timer and PLL lock detector
`timescale 1ns/1ps
`include "csfm_consts.svh"
module csfm_osc_model #(
   parameter int STARTUP_CYC = 20,
   parameter int LOCK_CYC = 30
) (
   input wire logic i_clk_sys,
   input wire logic [4:0] i_osc_enable,
   input wire logic i_fail_cmd,
   output logic o_osc_startup_done,
   output logic o_pll_locked,
   output logic o_osc_fail,
   output logic o_new_clk_toggle
);
   int ost_cnt = 0;
   int lock_cnt = 0;
   logic [2:0] div = 3'h0;

   // Start-up timer and lock detector restart when power is removed
   always @(posedge i_clk_sys) begin
      if (i_osc_enable[`CSFM_EN_PRI] | i_osc_enable[`CSFM_EN_SEC]) begin
         ost_cnt <= (ost_cnt < STARTUP_CYC) ? ost_cnt + 1 : ost_cnt;
      end else begin
         ost_cnt <= 0;
      end
      if (i_osc_enable[`CSFM_EN_PLL]) begin
         lock_cnt <= (lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt;
      end else begin
         lock_cnt <= 0;
      end
      if (|i_osc_enable) begin
         div <= div + 3'h1;
      end
   end

   // Ready flags only after the full delay, lost as soon as power drops
   assign o_osc_startup_done = (ost_cnt >= STARTUP_CYC);
   assign o_pll_locked = (lock_cnt >= LOCK_CYC);
   assign o_osc_fail = i_fail_cmd;
   // New clock stands still while every source is off
   assign o_new_clk_toggle = div[2];
endmodule

// ### bench/csfm_top_tb_top.sv
// Self-checking bench for the clock switch and fail monitor
`timescale 1ns/1ps
`include "csfm_consts.svh"
module csfm_top_tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h0;
   logic sw_mon = 1'b1;
   logic mon_off = 1'b0;
   logic [2:0] init_src = 3'h7;
   logic fail_cmd = 1'b0;
   logic wdt = 1'b0;
   logic [31:0] rdat;
   logic wait_rq;
   logic osc_startup_timer;
   logic lck;
   logic fail;
   logic tgl;
   logic trap;
   logic busy;
   logic [2:0] src;
   logic [4:0] oen;
   logic [8:0] pdiv;
   logic [5:0] tune;
   logic [31:0] got;
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;

   always #12.5 clk = ~clk;

   csfm_top i_csfm_top (.i_clk_sys(clk), .i_arst_n(arst_n),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdat), .i_avs_byteenable(be),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
      .i_cfg_switch_monitor(sw_mon), .i_cfg_monitor_off(mon_off),
      .i_cfg_initial_source(init_src), .i_cfg_primary_submode(2'h1),
      .i_wdt_enable(wdt), .i_sleep(1'b0), .i_osc_startup_done(osc_startup_timer),
      .i_pll_locked(lck), .i_osc_fail(fail), .i_new_clk_toggle(tgl),
      .o_sys_source(src), .o_osc_enable(oen),
      .o_pll_feedback_divisor(pdiv), .o_rc_tune_field(tune),
      .o_clock_fail_trap(trap), .o_switch_busy(busy));

   csfm_osc_model i_csfm_osc_model (.i_clk_sys(clk), .i_osc_enable(oen),
      .i_fail_cmd(fail_cmd), .o_osc_startup_done(osc_startup_timer),
      .o_pll_locked(lck), .o_osc_fail(fail), .o_new_clk_toggle(tgl));

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         summarize;
      end
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One bus cycle held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdat <= d;
      be <= b;
      do begin
         @(posedge clk);
      end while (wait_rq !== 1'b0);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic ctl_low(input logic [7:0] lo);
      bus(1'b1, `CSFM_OFS_KEY, {16'h0, `CSFM_KEY1}, 4'hf);
      bus(1'b1, `CSFM_OFS_KEY, {16'h0, `CSFM_KEY2}, 4'hf);
      bus(1'b1, `CSFM_OFS_OSC, {24'h0, lo}, 4'h1);
   endtask

   // Unlock, new source in high byte, unlock, request in low byte
   task automatic ctl_req(input logic [2:0] nsrc, input logic [7:0] lo);
      bus(1'b1, `CSFM_OFS_KEY, {16'h0, `CSFM_KEY1}, 4'hf);
      bus(1'b1, `CSFM_OFS_KEY, {16'h0, `CSFM_KEY2}, 4'hf);
      bus(1'b1, `CSFM_OFS_OSC, {21'h0, nsrc, 8'h00}, 4'h2);
      ctl_low(lo);
   endtask

   task automatic wait_done(output int cnt);
      cnt = 3;
      repeat (3) @(negedge clk);
      while (busy !== 1'b0 && cnt < 600) begin
         @(negedge clk);
         cnt++;
      end
      // A switch that never ends counts as a mismatch
      if (busy !== 1'b0) begin
         miscompares++;
      end
      repeat (3) @(negedge clk);
   endtask

   task automatic trap_seen(output int cnt);
      cnt = 0;
      @(posedge clk);
      fail_cmd <= 1'b1;
      repeat (24) begin
         @(negedge clk);
         cnt += int'(trap === 1'b1);
      end
      @(posedge clk);
      fail_cmd <= 1'b0;
   endtask

   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_disabled;
      ctl_req(3'h2, 8'h09);
      repeat (20) @(posedge clk);
      bus(1'b0, `CSFM_OFS_OSC, 32'h0, 4'hf);
      check(got & 32'h7001, 32'h7000);
      check({29'h0, src}, 32'h7);
      trap_seen(n);
      check(n, 0);
      $display("done: switching disabled");
   endtask

   task automatic t_regs;
      bus(1'b0, `CSFM_OFS_PLL, 32'h0, 4'hf);
      check(got, 32'h30);
      bus(1'b1, `CSFM_OFS_PLL, 32'hffffffff, 4'hf);
      bus(1'b0, `CSFM_OFS_PLL, 32'h0, 4'hf);
      check(got, 32'h1ff);
      check({23'h0, pdiv}, 32'h1ff);
      bus(1'b1, `CSFM_OFS_TUNE, 32'hffffffff, 4'hf);
      bus(1'b0, `CSFM_OFS_TUNE, 32'h0, 4'hf);
      check(got, 32'h3f);
      bus(1'b1, `CSFM_OFS_TUNE, 32'h20, 4'hf);
      bus(1'b0, `CSFM_OFS_TUNE, 32'h0, 4'hf);
      check({26'h0, tune}, 32'h20);
      bus(1'b1, 4'h2, 32'hffffffff, 4'hf);
      bus(1'b0, 4'h2, 32'h0, 4'hf);
      check(got, 32'h0);
      $display("done: register fields");
   endtask

   task automatic t_redundant;
      ctl_req(3'h0, 8'h09);
      wait_done(n);
      check({29'h0, src}, 32'h0);
      bus(1'b0, `CSFM_OFS_OSC, 32'h0, 4'hf);
      check(got & 32'h1, 32'h0);
      check({27'h0, oen}, 32'h09);
      $display("done: redundant request");
   endtask

   task automatic t_pripll;
      ctl_req(3'h3, 8'h09);
      bus(1'b0, `CSFM_OFS_PLL, 32'h0, 4'hf);
      check(got, 32'h30);
      @(negedge clk);
      check({31'h0, busy}, 32'h1);
      wait_done(n);
      check({29'h0, src}, 32'h3);
      bus(1'b0, `CSFM_OFS_OSC, 32'h0, 4'hf);
      check(got & 32'h7721, 32'h3320);
      check({27'h0, oen}, 32'h1a);
      $display("done: switch to primary with PLL");
   endtask

   task automatic t_fail;
      trap_seen(n);
      check(n, 1);
      check({29'h0, src}, 32'h1);
      bus(1'b0, `CSFM_OFS_OSC, 32'h0, 4'hf);
      check(got & 32'h8, 32'h8);
      $display("done: clock failure");
   endtask

   task automatic t_settle;
      ctl_req(3'h0, 8'h09);
      wait_done(n);
      check(n >= 42, 1);
      check({29'h0, src}, 32'h0);
      bus(1'b0, `CSFM_OFS_OSC, 32'h0, 4'hf);
      check(got & 32'h28, 32'h0);
      check({27'h0, oen}, 32'h09);
      $display("done: settle and fallback exit");
   endtask

   task automatic t_clock_source_lock;
      @(posedge clk);
      mon_off <= 1'b1;
      ctl_low(8'h88);
      ctl_req(3'h2, 8'h89);
      wait_done(n);
      check({29'h0, src}, 32'h0);
      ctl_low(8'h08);
      ctl_req(3'h2, 8'h09);
      wait_done(n);
      check({29'h0, src}, 32'h2);
      check({28'h0, oen[3:0]}, 32'h2);
      @(posedge clk);
      wdt <= 1'b1;
      repeat (3) @(negedge clk);
      check({31'h0, oen[3]}, 32'h1);
      $display("done: source lock");
   endtask

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      t_disabled;
      t_regs;
      @(posedge clk);
      arst_n <= 1'b0;
      sw_mon <= 1'b0;
      init_src <= 3'h0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      t_redundant;
      t_pripll;
      t_fail;
      t_settle;
      t_clock_source_lock;
      summarize;
   end
endmodule
